// File: cpp_pkg.sv
// Constants and carrier types for the crosspoint programming port.
// Assumes an 8x8 matrix with a 4-bit slot per output.
`default_nettype none

package cpp_pkg;

  localparam int OUTPUTS = 8;
  localparam int SOURCE_BITS = 3;
  localparam int INPUTS = 8;
  localparam int SLOT_BITS = 4;
  localparam int IMAGE_BITS = 32;
  // Position of the output-on bit and of the source field inside a slot
  localparam int SLOT_ON_POS = 0;
  localparam int SLOT_SRC_LSB = 1;
  // Bit leaving the shift register toward the next device
  localparam int SERIAL_OUT_POS = 31;
  localparam int SYNC_STAGES = 2;
  localparam logic [31:0] IMAGE_RESET = 32'h0000_0000;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic TOGGLE_RESET = 1'b0;

  // Parallel load pins, index fields binary with bit 0 as LSB
  typedef struct packed {
    logic [2:0] output_index;
    logic [2:0] source_index;
    logic output_on;
  } cpp_par_pins_type;

  // Serial link pins, all sampled on the falling edge of the link clock
  typedef struct packed {
    logic chip_select_n;
    logic port_mode_select;
    logic serial_in;
  } cpp_link_pins_type;

endpackage : cpp_pkg

`default_nettype wire

// File: cpp_port.sv
// Programming port of an 8x8 crosspoint: shift register, update latch and matrix.
// Assumes link pins change around the rising link clock edge and that the link
// clock period spans more than three system clock periods.
//
// Functional notes
// - Mode select low chooses serial loading via serial input, clock, select, strobe.
// - Shift register accepts data only while chip select is low.
// - Serial mode shifts serial input in on each falling link clock edge.
// - Each output slot: three source bits first, then the output-on bit.
// - Output-on zero disables the output and ignores its source bits.
// - Update latch is transparent while strobe is low; shifting reaches matrix.
// - Strobe low programs the matrix from current shift register contents.
// - Bits leaving the shift register appear on serial out for chaining.
// - Parallel falling edge writes the addressed slot; matrix waits for strobe.
// - Several slots may be loaded, then one low strobe applies all.
// - One output changes with one clock edge and one strobe, no reload.
// - Reset low disables all outputs; shift register keeps its contents.
// - Reset pin is active low; while low all outputs are disabled.
// - Output index pins are binary, lowest pin least significant.
// - Source index pins are binary, lowest pin LSB; fourth pin is output-on.
`default_nettype none

module cpp_port #(
  parameter int NUM_OUT = cpp_pkg::OUTPUTS
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Programming link, clocked by the controller
  input wire logic link_clk,
  input wire cpp_pkg::cpp_link_pins_type link_pins,
  input wire cpp_pkg::cpp_par_pins_type par_pins,
  output logic serial_out,
  // Device pins sampled in the system domain
  input wire logic update_n,
  input wire logic reset_n,
  // Matrix state
  output logic [NUM_OUT-1:0] out_enable,
  output logic [NUM_OUT-1:0][cpp_pkg::INPUTS-1:0] out_route
);

  localparam int IMG = NUM_OUT * cpp_pkg::SLOT_BITS;

  // ---------------- Link domain ----------------
  logic [IMG-1:0] shift_reg;
  logic [IMG-1:0] next_shift_reg;
  logic write_toggle;
  logic next_write_toggle;
  logic link_write;

  assign link_write = !link_pins.chip_select_n;

  always_comb begin
    next_shift_reg = shift_reg;
    next_write_toggle = write_toggle;
    if (link_write) begin
      next_write_toggle = !write_toggle;
      if (!link_pins.port_mode_select) begin
        next_shift_reg = {shift_reg[IMG-2:0], link_pins.serial_in};
      end else begin
        next_shift_reg[par_pins.output_index * cpp_pkg::SLOT_BITS +: cpp_pkg::SLOT_BITS] =
          {par_pins.source_index, par_pins.output_on};
      end
    end
  end

  // Only the system reset clears the shift register; the reset pin never touches it
  always_ff @(negedge link_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= IMG'(cpp_pkg::IMAGE_RESET);
      write_toggle <= cpp_pkg::TOGGLE_RESET;
    end else begin
      shift_reg <= next_shift_reg;
      write_toggle <= next_write_toggle;
    end
  end

  assign serial_out = shift_reg[IMG-1];

  // ---------------- System domain ----------------
  logic [cpp_pkg::SYNC_STAGES-1:0] tog_sync;
  logic [cpp_pkg::SYNC_STAGES-1:0] upd_sync;
  logic [cpp_pkg::SYNC_STAGES-1:0] rstn_sync;
  logic tog_seen;
  logic [IMG-1:0] image;
  logic [IMG-1:0] next_image;
  logic next_tog_seen;
  logic [NUM_OUT-1:0] next_out_enable;
  logic [NUM_OUT-1:0][cpp_pkg::INPUTS-1:0] next_out_route;
  logic update_low;
  logic reset_low;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_sync <= '0;
      upd_sync <= '1;
      rstn_sync <= '0;
    end else begin
      tog_sync <= {tog_sync[0], write_toggle};
      upd_sync <= {upd_sync[0], update_n};
      rstn_sync <= {rstn_sync[0], reset_n};
    end
  end

  assign update_low = !upd_sync[1];
  assign reset_low = !rstn_sync[1];

  // Capture a stable shift register copy after each link write
  always_comb begin
    next_tog_seen = tog_sync[1];
    next_image = image;
    if (tog_sync[1] != tog_seen) begin
      next_image = shift_reg;
    end
  end

  always_comb begin
    next_out_enable = out_enable;
    next_out_route = out_route;
    if (reset_low) begin
      next_out_enable = '0;
      next_out_route = '0;
    end else if (update_low) begin
      for (int k = 0; k < NUM_OUT; k++) begin
        next_out_enable[k] = image[k * cpp_pkg::SLOT_BITS + cpp_pkg::SLOT_ON_POS];
        next_out_route[k] = cpp_pkg::ROUTE_RESET;
        if (next_out_enable[k]) begin
          next_out_route[k][image[k * cpp_pkg::SLOT_BITS + cpp_pkg::SLOT_SRC_LSB +:
            cpp_pkg::SOURCE_BITS]] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_seen <= cpp_pkg::TOGGLE_RESET;
      image <= IMG'(cpp_pkg::IMAGE_RESET);
      out_enable <= '0;
      out_route <= '0;
    end else begin
      tog_seen <= next_tog_seen;
      image <= next_image;
      out_enable <= next_out_enable;
      out_route <= next_out_route;
    end
  end

  // ---------------- Assertions ----------------
  sequence s_serial_write;
    !link_pins.chip_select_n && !link_pins.port_mode_select;
  endsequence

  sequence s_par_write;
    !link_pins.chip_select_n && link_pins.port_mode_select;
  endsequence

  sequence s_apply;
    update_low && !reset_low;
  endsequence

  // Pin held long enough to pass both synchroniser stages
  sequence s_pin_reset_held;
    !reset_n [*3];
  endsequence

  sequence s_strobe_held;
    (!update_n && reset_n) [*3];
  endsequence

  property p_serial_shift;
    @(negedge link_clk) disable iff (rst)
    s_serial_write |=> shift_reg == {$past(shift_reg[IMG-2:0]), $past(link_pins.serial_in)};
  endproperty
  a_serial_shift: assert property (p_serial_shift) else $error("serial shift wrong");

  property p_deselected_hold;
    @(negedge link_clk) disable iff (rst)
    link_pins.chip_select_n |=> $stable(shift_reg) && $stable(write_toggle);
  endproperty
  a_deselected_hold: assert property (p_deselected_hold) else $error("deselected load");

  property p_chain_out;
    @(negedge link_clk) disable iff (rst)
    s_serial_write |=> serial_out == $past(shift_reg[IMG-2]);
  endproperty
  a_chain_out: assert property (p_chain_out) else $error("serial out not chained");

  property p_par_slot;
    @(negedge link_clk) disable iff (rst)
    s_par_write |=> shift_reg[$past(par_pins.output_index) * cpp_pkg::SLOT_BITS +:
      cpp_pkg::SLOT_BITS] == {$past(par_pins.source_index), $past(par_pins.output_on)};
  endproperty
  a_par_slot: assert property (p_par_slot) else $error("parallel slot wrong");

  property p_reset_disables;
    @(posedge clk) disable iff (rst)
    reset_low |=> out_enable == '0 && out_route == '0;
  endproperty
  a_reset_disables: assert property (p_reset_disables) else $error("outputs not disabled");

  property p_hold_high;
    @(posedge clk) disable iff (rst)
    !update_low && !reset_low |=> $stable(out_enable) && $stable(out_route);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("matrix changed, strobe high");

  property p_apply;
    @(posedge clk) disable iff (rst)
    update_low && !reset_low |=> out_enable[0] == $past(image[cpp_pkg::SLOT_ON_POS]);
  endproperty
  a_apply: assert property (p_apply) else $error("strobe did not apply image");

  property p_capture;
    @(posedge clk) disable iff (rst)
    tog_sync[1] != tog_seen |=> image == $past(shift_reg) ##1 tog_sync[1] == tog_seen;
  endproperty
  a_capture: assert property (p_capture) else $error("image not captured");

  property p_write_toggles;
    @(negedge link_clk) disable iff (rst)
    !link_pins.chip_select_n |=> write_toggle != $past(write_toggle);
  endproperty
  a_write_toggles: assert property (p_write_toggles) else $error("write not flagged");

  property p_out_hold;
    @(negedge link_clk) disable iff (rst)
    link_pins.chip_select_n |=> $stable(serial_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("serial out moved");

  // Capture must be done before the next link write can land
  property p_tog_gap;
    @(posedge clk) disable iff (rst)
    tog_sync[1] != tog_seen |=> (tog_sync[1] == tog_seen) [*2];
  endproperty
  a_tog_gap: assert property (p_tog_gap) else $error("writes too close");

  property p_keep_image;
    @(posedge clk) disable iff (rst)
    reset_low && tog_sync[1] == tog_seen |=> $stable(image);
  endproperty
  a_keep_image: assert property (p_keep_image) else $error("image lost");

  property p_pin_reset;
    @(posedge clk) disable iff (rst)
    s_pin_reset_held |=> out_enable == '0 && out_route == '0;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin did not disable");

  // A parallel write touches only the addressed slot
  generate
    for (genvar s = 0; s < NUM_OUT; s++) begin : g_slot_chk
      property p_par_keep;
        @(negedge link_clk) disable iff (rst)
        !link_pins.chip_select_n && link_pins.port_mode_select &&
          par_pins.output_index != s |=>
          $stable(shift_reg[s * cpp_pkg::SLOT_BITS +: cpp_pkg::SLOT_BITS]);
      endproperty
      a_par_keep: assert property (p_par_keep) else $error("other slot changed");
    end
  endgenerate

  generate
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_out_chk
      property p_off_no_route;
        @(posedge clk) disable iff (rst)
        !out_enable[g] |-> out_route[g] == '0;
      endproperty
      a_off_no_route: assert property (p_off_no_route) else $error("disabled output routed");

      property p_on_one_route;
        @(posedge clk) disable iff (rst)
        out_enable[g] |-> $onehot(out_route[g]);
      endproperty
      a_on_one_route: assert property (p_on_one_route) else $error("route not one-hot");

      // Strobe applies every slot, not only output zero
      property p_apply_on;
        @(posedge clk) disable iff (rst)
        s_apply |=>
          out_enable[g] == $past(image[g * cpp_pkg::SLOT_BITS + cpp_pkg::SLOT_ON_POS]);
      endproperty
      a_apply_on: assert property (p_apply_on) else $error("slot not applied");

      property p_apply_src;
        @(posedge clk) disable iff (rst)
        s_apply |=> !out_enable[g] || out_route[g][$past(image[g * cpp_pkg::SLOT_BITS +
          cpp_pkg::SLOT_SRC_LSB +: cpp_pkg::SOURCE_BITS])];
      endproperty
      a_apply_src: assert property (p_apply_src) else $error("wrong source applied");

      property p_strobe_pin;
        @(posedge clk) disable iff (rst)
        s_strobe_held |=>
          out_enable[g] == $past(image[g * cpp_pkg::SLOT_BITS + cpp_pkg::SLOT_ON_POS]);
      endproperty
      a_strobe_pin: assert property (p_strobe_pin) else $error("strobe pin not applied");
    end
  endgenerate

endmodule : cpp_port

`default_nettype wire

// File: cpp_ctrl.sv
// Controller model driving the programming pins of the port.
// Assumes the bench calls its tasks one at a time.
`default_nettype none
module cpp_ctrl (
  // Link pins
  output logic link_clk,
  output var cpp_pkg::cpp_link_pins_type link_pins,
  output var cpp_pkg::cpp_par_pins_type par_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_clk = 1'b1;
    link_pins = 3'b100;
    par_pins = 7'h00;
  end
  // Clock idles high; one falling edge per call
  task automatic pulse();
    #23 link_clk = 1'b0;
    #40 link_clk = 1'b1;
  endtask : pulse
  // Pins drop well after the rising edge, never in the step of the next call
  task automatic shift(input logic cs_n, input logic b);
    link_pins = {cs_n, 1'b0, b};
    pulse();
    #10 link_pins = {1'b1, 1'b0, ~b};
    #7;
  endtask : shift
  task automatic par_write(input logic [2:0] k, input logic [2:0] s, input logic on);
    link_pins = 3'b010;
    par_pins = {k, s, on};
    pulse();
    #10 link_pins = 3'b110;
    par_pins = ~par_pins;
    #7;
  endtask : par_write
endmodule : cpp_ctrl
`default_nettype wire

// File: cpp_port_tb.sv
// Self-checking bench for the crosspoint programming port.
// Assumes cpp_pkg, cpp_port and the controller model cpp_ctrl.
`default_nettype none
module cpp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic update_n = 1'b1;
  logic reset_n = 1'b0;
  logic link_clk;
  logic serial_out;
  cpp_pkg::cpp_link_pins_type link_pins;
  cpp_pkg::cpp_par_pins_type par_pins;
  logic [7:0] out_enable;
  logic [7:0][7:0] out_route;
  logic [31:0] msr = cpp_pkg::IMAGE_RESET;
  logic [31:0] app = 32'h0;
  logic [31:0] seed = 32'h5FCF7579;
  int chain_q[$];
  int failures = 0;
  int compares = 0;
  cpp_ctrl cpp_ctrl_inst (.link_clk(link_clk), .link_pins(link_pins), .par_pins(par_pins));
  cpp_port cpp_port_inst (.clk(clk), .rst(rst), .link_clk(link_clk), .link_pins(link_pins),
    .par_pins(par_pins), .serial_out(serial_out), .update_n(update_n), .reset_n(reset_n),
    .out_enable(out_enable), .out_route(out_route));
  initial begin
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic check_matrix(input logic [31:0] img, input logic en);
    logic [63:0] route;
    logic [7:0] ena;
    route = '0;
    for (int k = 0; k < 8; k++) begin
      ena[k] = en & img[4*k];
      if (ena[k]) route[8*k+img[4*k+1+:3]] = 1'b1;
    end
    check("out_enable", {56'h0, ena}, {56'h0, out_enable});
    check("out_route", route, out_route);
  endtask : check_matrix
  task automatic load_serial(input logic [31:0] img, input logic cs_n, input int nbits);
    logic exp_out;
    for (int i = 31; i >= 32 - nbits; i--) begin
      cpp_ctrl_inst.shift(cs_n, img[i]);
      if (!cs_n) msr = {msr[30:0], img[i]};
      if (!cs_n) chain_q.push_back(int'(img[i]));
      exp_out = chain_q[chain_q.size() - 32] != 0;
      check("serial_out", {63'h0, exp_out}, {63'h0, serial_out});
    end
  endtask : load_serial
  // Parallel write lands in the model image and in the bit history alike
  task automatic par_model(input int k, input logic [3:0] slot);
    msr[4*k+:4] = slot;
    for (int j = 0; j < 4; j++) chain_q[chain_q.size() - 1 - 4*k - j] = int'(slot[j]);
  endtask : par_model
  task automatic apply();
    settle(1);
    update_n = 1'b0;
    app = msr;
    settle(6);
    check_matrix(app, 1'b1);
    update_n = 1'b1;
    settle(4);
  endtask : apply
  task automatic report_and_stop();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #300us;
    failures++;
    report_and_stop();
  end
  initial begin
    for (int i = 31; i >= 0; i--) chain_q.push_back(int'(cpp_pkg::IMAGE_RESET[i]));
    settle(8);
    rst = 1'b0;
    settle(4);
    check_matrix(app, 1'b0);
    reset_n = 1'b1;
    for (int n = 0; n < 3; n++) begin
      load_serial(rnd(), 1'b0, 32);
      check_matrix(app, 1'b1);
      apply();
    end
    load_serial(rnd(), 1'b1, 32);
    apply();
    for (int k = 7; k >= 0; k--) begin
      cpp_ctrl_inst.par_write(k[2:0], seed[3:1], seed[0]);
      par_model(k, seed[3:0]);
      void'(rnd());
    end
    check_matrix(app, 1'b1);
    apply();
    cpp_ctrl_inst.par_write(seed[6:4], seed[3:1], 1'b1);
    par_model(int'(seed[6:4]), {seed[3:1], 1'b1});
    apply();
    settle(1);
    update_n = 1'b0;
    load_serial(rnd(), 1'b0, 16);
    settle(8);
    check_matrix(msr, 1'b1);
    reset_n = 1'b0;
    settle(6);
    check_matrix(msr, 1'b0);
    reset_n = 1'b1;
    settle(6);
    check_matrix(msr, 1'b1);
    report_and_stop();
  end
endmodule : cpp_port_tb
`default_nettype wire
